// ### bench/spr_board_model.sv
// board model that resolves the two input status pins
`timescale 1ns/100ps
`default_nettype none
module spr_board_model
  import spr_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] status_pin_out,
  input wire logic [3:0] status_pin_oe_n,
  input wire logic [1:0] status_pull_up,
  input wire logic [1:0] status_pull_dn,
  input wire logic [1:0] board_level,
  input wire logic [1:0] board_drive,
  output logic [1:0] status_sel_pin_in
);
  logic float_ff = 1'b0;
  // a floating pin wanders, so nothing may rely on a stale level
  always @(posedge clk) float_ff <= !float_ff;
  // device driver wins, then the board, then the pull resistors
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!status_pin_oe_n[i+2]) status_sel_pin_in[i] = status_pin_out[i+2];
      else if (board_drive[i]) status_sel_pin_in[i] = board_level[i];
      else if (status_pull_up[i]) status_sel_pin_in[i] = 1'b1;
      else if (status_pull_dn[i]) status_sel_pin_in[i] = 1'b0;
      else status_sel_pin_in[i] = float_ff ^ i[0];
    end
  end
endmodule
`default_nettype wire

// ### bench/spr_checker.sv
// assertion checker for the status pin and reference select block
`timescale 1ns/100ps
`default_nettype none
module spr_checker
  import spr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic prog_latch,
  input wire logic ref_loop_lock_detect,
  input wire logic synth_loop_lock_detect,
  input wire logic [3:0] status_pin_oe_n,
  input wire logic [1:0] status_pull_up,
  input wire logic [1:0] status_pull_dn,
  input wire logic [1:0] ref_select,
  input wire logic holdover_active,
  input wire logic sync_force,
  input wire logic dac_track_en
);
  logic [3:0] since_latch_ff;
  // cycles since the latch pin was high; config outputs may only move shortly after a commit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since_latch_ff <= 4'hF;
    end else if (prog_latch) begin
      since_latch_ff <= 4'h0;
    end else if (since_latch_ff != 4'hF) begin
      since_latch_ff <= since_latch_ff + 4'h1;
    end
  end
  // ********
  // properties
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_both_locked;
    ref_loop_lock_detect && synth_loop_lock_detect;
  endsequence
  sequence s_in0_pulled;
    status_pull_up[0] || status_pull_dn[0];
  endsequence
  a_sync_lock_clear: assert property (s_both_locked |=> !sync_force)
    else $error("sync forced while both loops locked");
  a_sync_needs_unlock: assert property (
    sync_force |-> $past(!ref_loop_lock_detect || !synth_loop_lock_detect))
    else $error("sync forced with no loop unlocked");
  a_sel_in_range: assert property (ref_select != 2'h3)
    else $error("reference select out of range");
  a_pull_one_way: assert property ((status_pull_up & status_pull_dn) == 2'h0)
    else $error("pull-up and pull-down both on");
  a_pulled_released: assert property (s_in0_pulled |-> status_pin_oe_n[2])
    else $error("input-typed pin is driven");
  a_in1_released: assert property (
    status_pin_oe_n[3] && status_pull_up[1] == 1'b0 && status_pull_dn[1] == 1'b0)
    else $error("second input pin not released");
  a_hold_lock_clear: assert property (ref_loop_lock_detect |=> !holdover_active)
    else $error("holdover kept while ref loop locked");
  a_hold_needs_fall: assert property (
    $rose(holdover_active) |-> $past(!ref_loop_lock_detect))
    else $error("holdover entered without lock loss");
  a_track_after_write: assert property (
    $changed(dac_track_en) |-> since_latch_ff < 4'h8)
    else $error("tracking enable moved without a write");
  a_pull_after_write: assert property (
    $changed({status_pull_up, status_pull_dn}) |-> since_latch_ff < 4'h8)
    else $error("pull setting moved without a write");
endmodule
`default_nettype wire

// ### bench/tb_status_pin_and_ref_select_config.sv
// self-checking bench for the status pin and reference select block
`timescale 1ns/100ps
`default_nettype none
module tb_status_pin_and_ref_select_config
  import spr_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic prog_clk = 1'b0;
  logic prog_data = 1'b0;
  logic prog_latch = 1'b0;
  logic ref_lock = 1'b1;
  logic synth_lock = 1'b1;
  logic [3:0] dac_bits = 4'h0;
  logic [2:0] los = 3'h0;
  logic [1:0] board_level = 2'h0;
  logic [1:0] board_drive = 2'h0;
  logic [1:0] sel_pins;
  logic [3:0] status_pin_out;
  logic [3:0] status_pin_oe_n;
  logic [1:0] status_pull_up;
  logic [1:0] status_pull_dn;
  logic [1:0] ref_select;
  logic holdover_active;
  logic clock_switch_event;
  logic sync_force;
  logic dac_track_en;
  logic [7:0] sw_cnt = 8'h0;
  logic [7:0] exp_sw = 8'h0;
  logic [1:0] v;
  logic [11:0] note;
  logic [11:0] notes[$];
  int seed = 32'hA9E49902;
  int tests_run = 0;
  int bad_count = 0;
  // 200 MHz clock
  always #2.5 clk = !clk;
  spr_status_ref_select i_dut (
    .clk, .reset_n, .prog_clk, .prog_data, .prog_latch, .status_sel_pin_in(sel_pins),
    .ref_loop_lock_detect(ref_lock), .synth_loop_lock_detect(synth_lock),
    .dac_locked(dac_bits[3]), .dac_rail(dac_bits[2]),
    .dac_low(dac_bits[1]), .dac_high(dac_bits[0]),
    .dac_count(10'h0), .ref_input_los(los), .divider_pulse(4'h0),
    .status_pin_out, .status_pin_oe_n, .status_pull_up, .status_pull_dn, .ref_select,
    .holdover_active, .clock_switch_event, .sync_force, .dac_track_en
  );
  spr_board_model i_board (
    .clk, .status_pin_out, .status_pin_oe_n, .status_pull_up, .status_pull_dn,
    .board_level, .board_drive, .status_sel_pin_in(sel_pins)
  );
  // ********
  // helpers
  // ********
  function automatic logic [31:0] w12(input logic [4:0] s, input logic [2:0] t,
      input logic [2:0] stb, input logic [1:0] ho);
    return {s, t, stb[2:1], 13'h0, stb[0], ho, 1'b0, ADDR_LOCK_HOLD};
  endfunction
  function automatic logic [31:0] w13(input logic [4:0] hs, input logic [2:0] ht,
      input logic [2:0] it, input logic [2:0] is, input logic ign, input logic [2:0] md,
      input logic inv, input logic [2:0] en);
    return {hs, ht, 4'h0, 1'b0, it, ign, is, md, inv, en, ADDR_PIN_REFSEL};
  endfunction
  // expected {level, enable_n} of an output-typed pin
  function automatic logic [7:0] pin(input logic [2:0] t, input logic s);
    case (t)
      TY_PUSH: return {6'h0, s, 1'b0};
      TY_PUSH_INV: return {6'h0, !s, 1'b0};
      TY_OPEN_SRC: return {6'h0, 1'b1, !s};
      TY_OPEN_DRN: return {6'h0, 1'b0, s};
      default: return 8'h0;
    endcase
  endfunction
  function automatic logic src(input int c);
    case (c)
      1: return ref_lock;
      2: return synth_lock;
      3: return ref_lock & synth_lock;
      5: return dac_bits[3];
      8: return dac_bits[2];
      9: return dac_bits[1];
      10: return dac_bits[0];
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [7:0] probe(input logic [3:0] s);
    case (s)
      4'h0: return {6'h0, status_pin_out[0], status_pin_oe_n[0]};
      4'h1: return {6'h0, status_pin_out[1], status_pin_oe_n[1]};
      4'h2: return {6'h0, status_pin_out[2], status_pin_oe_n[2]};
      4'h3: return {7'h0, status_pin_oe_n[2]};
      4'h4: return {6'h0, status_pull_up[0], status_pull_dn[0]};
      4'h5: return {6'h0, ref_select};
      4'h6: return {7'h0, holdover_active};
      4'h7: return {7'h0, sync_force};
      4'h8: return {7'h0, dac_track_en};
      default: return sw_cnt;
    endcase
  endfunction
  // serial word, MSB first, slow phases so the pin synchronisers never miss an edge
  task automatic wr(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      prog_data = w[i];
      repeat (4) @(negedge clk);
      prog_clk = 1'b1;
      repeat (4) @(negedge clk);
      prog_clk = 1'b0;
    end
    repeat (4) @(negedge clk);
    prog_latch = 1'b1;
    repeat (4) @(negedge clk);
    prog_latch = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic chk(input logic [3:0] s, input logic [7:0] e);
    notes.push_back({s, e});
    @(negedge clk);
  endtask
  task automatic kick(input logic [2:0] l, input logic rl, input logic [1:0] want);
    los = l;
    ref_lock = rl;
    @(negedge clk);
    los = 3'h0;
    ref_lock = 1'b1;
    repeat (4) @(negedge clk);
    exp_sw = exp_sw + 8'h1;
    chk(4'h5, {6'h0, want});
    chk(4'h9, exp_sw);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // monitor: counts switch pulses and settles the oldest note each edge
  always @(posedge clk) begin
    if (clock_switch_event === 1'b1) sw_cnt <= sw_cnt + 8'h1;
    if (notes.size() > 0) begin
      note = notes.pop_front();
      tests_run++;
      if (probe(note[11:8]) !== note[7:0]) begin
        bad_count++;
        $display("CHECK FAILED %0t: slot %0d got %h want %h", $time, note[11:8],
          probe(note[11:8]), note[7:0]);
      end
    end
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(4'h0, 8'h0);
    chk(4'h1, 8'h0);
    chk(4'h3, 8'h1);
    chk(4'h8, 8'h0);
    // source codes 0 to 10 except 6 and 7 under every drive type, on the lock and holdover pins
    for (int c = 0; c <= 10; c++) begin
      for (int t = 0; t <= 6; t++) begin
        if (c == 6 || c == 7) continue;
        {ref_lock, synth_lock, dac_bits} = 6'($random(seed));
        wr(w12(5'(c), 3'(t), 3'h0, HO_MODE_OFF));
        chk(4'h0, pin(3'(t), src(c)));
        wr(w13(5'(c), 3'(t), 3'h0, 3'h0, 1'b1, 3'h0, 1'b0, 3'h1));
        chk(4'h1, pin(3'(t), src(c)));
      end
    end
    // input pin: input types release it, output types route its loss signal
    for (int t = 0; t <= 6; t++) begin
      los = 3'($random(seed));
      wr(w13(5'h0, TY_PUSH, 3'(t), 3'h1, 1'b1, 3'h0, 1'b0, 3'h1));
      if (t < 3) begin
        chk(4'h3, 8'h1);
        chk(4'h4, {6'h0, t == 1, t == 2});
      end else chk(4'h2, pin(3'(t), los[0]));
    end
    los = 3'h0;
    // sync hold bits and tracking against each lock combination
    for (int m = 0; m < 8; m++) begin
      wr(w12(5'h0, TY_PUSH, 3'(m), HO_MODE_OFF));
      chk(4'h8, {7'h0, m[0]});
      for (int k = 0; k < 4; k++) begin
        {ref_lock, synth_lock} = 2'(k);
        @(negedge clk);
        chk(4'h7, {7'h0, (m[2] & !synth_lock) | (m[1] & !ref_lock)});
      end
    end
    // holdover: disabled, enabled, enabled with lock loss ignored
    ref_lock = 1'b1;
    for (int h = 0; h < 3; h++) begin
      wr(w13(5'h4, TY_PUSH, 3'h0, 3'h0, h == 2, 3'h0, 1'b0, 3'h1));
      wr(w12(5'h0, TY_PUSH, 3'h0, h == 0 ? HO_MODE_OFF : HO_MODE_ON));
      ref_lock = 1'b0;
      repeat (3) @(negedge clk);
      chk(4'h6, {7'h0, h == 1});
      chk(4'h1, {6'h0, h == 1, 1'b0});
      ref_lock = 1'b1;
      repeat (3) @(negedge clk);
      chk(4'h6, 8'h0);
    end
    // manual modes, then a reserved mode that must hold the choice
    for (int r = 0; r < 3; r++) begin
      wr(w13(5'h0, TY_PUSH, 3'h0, 3'h0, 1'b1, 3'(r), 1'b0, 3'h7));
      chk(4'h5, 8'(r));
    end
    wr(w13(5'h0, TY_PUSH, 3'h0, 3'h0, 1'b1, 3'h5, 1'b0, 3'h7));
    chk(4'h5, 8'h2);
    // pin select mode under both polarities; the board keeps driving afterwards
    board_drive = 2'h3;
    for (int p = 0; p < 8; p++) begin
      board_level = 2'(p);
      v = 2'(p) ^ {2{p[2]}};
      wr(w13(5'h0, TY_PUSH, 3'h0, 3'h0, 1'b1, RM_PIN, p[2], 3'h7));
      chk(4'h5, v == 2'h3 ? 8'h0 : {6'h0, v});
    end
    chk(4'h9, exp_sw);
    // automatic switching with input 1 disabled, then all enabled
    wr(w13(5'h0, TY_PUSH, 3'h0, 3'h0, 1'b0, RM_AUTO, 1'b1, 3'h5));
    kick(3'h1, 1'b1, 2'h2);
    kick(3'h4, 1'b1, 2'h0);
    wr(w13(5'h0, TY_PUSH, 3'h0, 3'h0, 1'b0, RM_AUTO, 1'b1, 3'h7));
    kick(3'h0, 1'b0, 2'h1);
    repeat (4) @(negedge clk);
    end_of_test;
  end
endmodule
bind spr_status_ref_select spr_checker i_chk (.clk, .reset_n, .prog_latch,
  .ref_loop_lock_detect, .synth_loop_lock_detect, .status_pin_oe_n, .status_pull_up,
  .status_pull_dn, .ref_select, .holdover_active, .sync_force, .dac_track_en);
`default_nettype wire

// ### inc/spr_pkg.sv
// constants, field layouts and carrier types for the status pin and reference select block
// ****************************************************************
// Functional notes
// - lock pin picks one of nineteen sources
// - drive type 3 true, 4 inverted
// - lock pin types: push-pull, inverted, open-source, open-drain
// - sync held asserted until chosen loop locks
// - tracking bit lets DAC follow ref loop
// - holdover code 1 off, code 2 on
// - holdover pin shares lock pin source codes
// - holdover pin types match lock pin types
// - input status pins pick seven sources each
// - input pin type sets input or output function; second pin fixed at RST_IN1_TYPE, always an input here
// - ref lock loss enters holdover, switches clock
// - mode field: manual, pin, auto, auto+pin
// - polarity bit inverts select pins as inputs
// - disabled inputs never chosen automatically
// - auto order 0, 1, 2, back to 0
// ****************************************************************
package spr_pkg;
  // register indices carried in the low address bits of each serial word
  localparam logic [4:0] ADDR_LOCK_HOLD = 5'h0C;
  localparam logic [4:0] ADDR_PIN_REFSEL = 5'h0D;
  localparam logic [4:0] ADDR_DAC_READBACK = 5'h17;
  localparam int ADDR_W = 5;
  localparam int WORD_W = 32;
  localparam logic [31:0] RST_LOCK_HOLD = 32'h0300_004C;
  localparam logic [31:0] RST_PIN_REFSEL = 32'h0300_002D;
  // lock pin and holdover control word
  localparam int LK_SRC_LSB = 27;
  localparam int LK_TYPE_LSB = 24;
  localparam int SYNC_SYNTH_BIT = 23;
  localparam int SYNC_REF_BIT = 22;
  localparam int TRACK_BIT = 8;
  localparam int HO_MODE_LSB = 6;
  // status pin and reference select word
  localparam int HO_SRC_LSB = 27;
  localparam int HO_TYPE_LSB = 24;
  localparam int IN1_SRC_LSB = 20;
  localparam int IN0_TYPE_LSB = 16;
  localparam int LOSS_IGN_BIT = 15;
  localparam int IN0_SRC_LSB = 12;
  localparam int REF_MODE_LSB = 9;
  localparam int SEL_INV_BIT = 8;
  localparam int AUTO_EN_LSB = 5;
  // the second input pin type lives in the next word, kept here locally
  localparam logic [2:0] RST_IN1_TYPE = 3'h0;
  localparam int DAC_COUNT_READBACK_W = 10;
  localparam int DAC_COUNT_READBACK_LSB = 14;
  localparam logic [1:0] HO_MODE_OFF = 2'h1;
  localparam logic [1:0] HO_MODE_ON = 2'h2;
  // pin drive types
  localparam logic [2:0] TY_IN_PU = 3'h1;
  localparam logic [2:0] TY_IN_PD = 3'h2;
  localparam logic [2:0] TY_PUSH = 3'h3;
  localparam logic [2:0] TY_PUSH_INV = 3'h4;
  localparam logic [2:0] TY_OPEN_SRC = 3'h5;
  localparam logic [2:0] TY_OPEN_DRN = 3'h6;
  // reference select modes
  localparam logic [2:0] RM_PIN = 3'h3;
  localparam logic [2:0] RM_AUTO = 3'h4;
  localparam logic [2:0] RM_AUTO_PIN = 3'h6;
  // internal sources that the pin multiplexers can route
  typedef struct packed {
    logic ref_lock;
    logic synth_lock;
    logic holdover;
    logic dac_locked;
    logic readback;
    logic dac_rail;
    logic dac_low;
    logic dac_high;
    logic [3:0] div_full;
    logic [3:0] div_half;
  } spr_src_s;
  // pin level and enable pair, enable active low
  typedef struct packed {
    logic out;
    logic oe_n;
  } spr_drive_s;
endpackage

// ### rtl/spr_status_ref_select.sv
// status pin routing, pin drive types and reference input selection
`timescale 1ns/100ps
`default_nettype none
module spr_status_ref_select
  import spr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic prog_clk,
  input wire logic prog_data,
  input wire logic prog_latch,
  input wire logic [1:0] status_sel_pin_in,
  input wire logic ref_loop_lock_detect,
  input wire logic synth_loop_lock_detect,
  input wire logic dac_locked,
  input wire logic dac_rail,
  input wire logic dac_low,
  input wire logic dac_high,
  input wire logic [DAC_COUNT_READBACK_W-1:0] dac_count,
  input wire logic [2:0] ref_input_los,
  input wire logic [3:0] divider_pulse,
  output logic [3:0] status_pin_out,
  output logic [3:0] status_pin_oe_n,
  output logic [1:0] status_pull_up,
  output logic [1:0] status_pull_dn,
  output logic [1:0] ref_select,
  output logic holdover_active,
  output logic clock_switch_event,
  output logic sync_force,
  output logic dac_track_en
);
  // ****************************************************************
  // helper functions
  // ****************************************************************
  // nineteen-way source decode shared by lock and holdover pins
  function automatic logic wide_src(input logic [4:0] code, input spr_src_s s);
    logic v;
    v = 1'b0;
    case (code)
      5'h01: v = s.ref_lock;
      5'h02: v = s.synth_lock;
      5'h03: v = s.ref_lock & s.synth_lock;
      5'h04: v = s.holdover;
      5'h05: v = s.dac_locked;
      5'h07: v = s.readback;
      5'h08: v = s.dac_rail;
      5'h09: v = s.dac_low;
      5'h0A: v = s.dac_high;
      5'h0B: v = s.div_full[0];
      5'h0C: v = s.div_half[0];
      5'h0D: v = s.div_full[1];
      5'h0E: v = s.div_half[1];
      5'h0F: v = s.div_full[2];
      5'h10: v = s.div_half[2];
      5'h11: v = s.div_full[3];
      5'h12: v = s.div_half[3];
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // seven-way decode for an input status pin
  function automatic logic narrow_src(input logic [2:0] code, input logic los,
                                      input logic chosen, input spr_src_s s);
    logic v;
    v = 1'b0;
    case (code)
      3'h1: v = los;
      3'h2: v = chosen;
      3'h3: v = s.dac_locked;
      3'h4: v = s.dac_low;
      3'h5: v = s.dac_high;
      3'h6: v = s.readback;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // level and enable for a pin type; input types release the pin only when may_input is set
  function automatic spr_drive_s pin_drive(input logic [2:0] ty, input logic v,
                                           input logic may_input);
    spr_drive_s d;
    d.out = 1'b0;
    d.oe_n = 1'b0;
    case (ty)
      TY_PUSH: d.out = v;
      TY_PUSH_INV: d.out = ~v;
      TY_OPEN_SRC: begin
        d.out = 1'b1;
        d.oe_n = ~v;
      end
      TY_OPEN_DRN: begin
        d.out = 1'b0;
        d.oe_n = v;
      end
      3'h0, TY_IN_PU, TY_IN_PD: d.oe_n = may_input;
      default: d.oe_n = 1'b0;
    endcase
    return d;
  endfunction

  // next enabled input after cur in circular order, cur if none
  function automatic logic [1:0] next_enabled(input logic [1:0] cur, input logic [2:0] en);
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] r;
    a = (cur == 2'h2) ? 2'h0 : 2'(cur + 2'h1);
    b = (a == 2'h2) ? 2'h0 : 2'(a + 2'h1);
    r = cur;
    if (en[a]) begin
      r = a;
    end else if (en[b]) begin
      r = b;
    end
    return r;
  endfunction

  // ****************************************************************
  // serial programming port
  // ****************************************************************
  logic [2:0] prog_meta_ff;
  logic [2:0] prog_sync_ff;
  logic [2:0] prog_prev_ff;
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] lock_word_ff;
  logic [WORD_W-1:0] pin_word_ff;
  logic [WORD_W-1:0] readback_ff;
  logic [DAC_COUNT_READBACK_W-1:0] dac_count_readback_ff;
  logic prog_clk_rise;
  logic prog_latch_rise;
  logic [ADDR_W-1:0] wr_addr;

  // pins are asynchronous, two stages before anything looks at them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_meta_ff <= 3'h0;
      prog_sync_ff <= 3'h0;
      prog_prev_ff <= 3'h0;
    end else begin
      prog_meta_ff <= {prog_latch, prog_data, prog_clk};
      prog_sync_ff <= prog_meta_ff;
      prog_prev_ff <= prog_sync_ff;
    end
  end

  assign prog_clk_rise = prog_sync_ff[0] & ~prog_prev_ff[0] & ~prog_sync_ff[2];
  assign prog_latch_rise = prog_sync_ff[2] & ~prog_prev_ff[2];
  assign wr_addr = shift_ff[ADDR_W-1:0];

  // msb first; the word is committed on the rising latch edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_ff <= 32'h0000_0000;
    end else if (prog_clk_rise) begin
      shift_ff <= {shift_ff[WORD_W-2:0], prog_sync_ff[1]};
    end
  end

  // writes to other addresses belong to other blocks and are ignored here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_word_ff <= RST_LOCK_HOLD;
      pin_word_ff <= RST_PIN_REFSEL;
    end else if (prog_latch_rise) begin
      if (wr_addr == ADDR_LOCK_HOLD) begin
        lock_word_ff <= shift_ff;
      end else if (wr_addr == ADDR_PIN_REFSEL) begin
        pin_word_ff <= shift_ff;
      end
    end
  end

  // tracked DAC count is kept while tracking is on, held otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_count_readback_ff <= 10'h000;
    end else if (lock_word_ff[TRACK_BIT]) begin
      dac_count_readback_ff <= dac_count;
    end
  end

  // readback word loads on latch, then shifts out on each serial clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readback_ff <= 32'h0000_0000;
    end else if (prog_latch_rise) begin
      if (wr_addr == ADDR_LOCK_HOLD) begin
        readback_ff <= lock_word_ff;
      end else if (wr_addr == ADDR_PIN_REFSEL) begin
        readback_ff <= pin_word_ff;
      end else if (wr_addr == ADDR_DAC_READBACK) begin
        readback_ff <= WORD_W'(dac_count_readback_ff) << DAC_COUNT_READBACK_LSB;
      end else begin
        readback_ff <= 32'h0000_0000;
      end
    end else if (prog_clk_rise) begin
      readback_ff <= {readback_ff[WORD_W-2:0], 1'b0};
    end
  end

  // ****************************************************************
  // field views
  // ****************************************************************
  logic [4:0] lk_src;
  logic [2:0] lk_type;
  logic [4:0] ho_src;
  logic [2:0] ho_type;
  logic [2:0] in_src [2];
  logic [2:0] in_type [2];
  logic [1:0] ho_mode;
  logic [2:0] ref_mode;
  logic [2:0] auto_en;
  logic loss_ignore;
  logic sel_inv;

  assign lk_src = lock_word_ff[LK_SRC_LSB +: 5];
  assign lk_type = lock_word_ff[LK_TYPE_LSB +: 3];
  assign ho_mode = lock_word_ff[HO_MODE_LSB +: 2];
  assign ho_src = pin_word_ff[HO_SRC_LSB +: 5];
  assign ho_type = pin_word_ff[HO_TYPE_LSB +: 3];
  assign in_src[0] = pin_word_ff[IN0_SRC_LSB +: 3];
  assign in_src[1] = pin_word_ff[IN1_SRC_LSB +: 3];
  assign in_type[0] = pin_word_ff[IN0_TYPE_LSB +: 3];
  assign in_type[1] = RST_IN1_TYPE;
  assign loss_ignore = pin_word_ff[LOSS_IGN_BIT];
  assign ref_mode = pin_word_ff[REF_MODE_LSB +: 3];
  assign sel_inv = pin_word_ff[SEL_INV_BIT];
  assign auto_en = pin_word_ff[AUTO_EN_LSB +: 3];

  // ****************************************************************
  // select pins, lock events and holdover
  // ****************************************************************
  logic [1:0] sel_meta_ff;
  logic [1:0] sel_sync_ff;
  logic ref_lock_prev_ff;
  logic holdover_ff;
  logic switch_ff;
  logic [1:0] ref_sel_ff;
  logic [1:0] pin_choice;
  logic lock_fall;
  logic switch_req;

  // select pins cross in through two stages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_meta_ff <= 2'h0;
      sel_sync_ff <= 2'h0;
      ref_lock_prev_ff <= 1'b0;
    end else begin
      sel_meta_ff <= status_sel_pin_in;
      sel_sync_ff <= sel_meta_ff;
      ref_lock_prev_ff <= ref_loop_lock_detect;
    end
  end

  // polarity applied to the pins as inputs; code 3 folds back to input 0
  assign pin_choice = ((sel_sync_ff ^ {2{sel_inv}}) == 2'h3) ? 2'h0
                    : (sel_sync_ff ^ {2{sel_inv}});
  assign lock_fall = ref_lock_prev_ff & ~ref_loop_lock_detect;
  // loss of the active input also counts as a switch cause in auto modes
  assign switch_req = (lock_fall & ~loss_ignore) | ref_input_los[ref_sel_ff];

  // holdover entered on lock loss only when the mode code says enabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      holdover_ff <= 1'b0;
    end else if (ho_mode != HO_MODE_ON) begin
      holdover_ff <= 1'b0;
    end else if (lock_fall & ~loss_ignore) begin
      holdover_ff <= 1'b1;
    end else if (ref_loop_lock_detect) begin
      holdover_ff <= 1'b0;
    end
  end

  // reference choice; reserved modes keep the current input
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_sel_ff <= 2'h0;
      switch_ff <= 1'b0;
    end else begin
      switch_ff <= 1'b0;
      if (ref_mode <= 3'h2) begin
        ref_sel_ff <= ref_mode[1:0];
      end else if (ref_mode == RM_PIN) begin
        ref_sel_ff <= pin_choice;
      end else if (ref_mode == RM_AUTO && switch_req) begin
        ref_sel_ff <= next_enabled(ref_sel_ff, auto_en);
        switch_ff <= 1'b1;
      end else if (ref_mode == RM_AUTO_PIN && switch_req) begin
        ref_sel_ff <= auto_en[pin_choice] ? pin_choice
                    : next_enabled(ref_sel_ff, auto_en);
        switch_ff <= 1'b1;
      end else if (ref_mode != RM_AUTO && ref_mode != RM_AUTO_PIN) begin
        ref_sel_ff <= ref_sel_ff;
      end
    end
  end

  // ****************************************************************
  // divider taps, half rate by toggling on each pulse
  // ****************************************************************
  logic [3:0] div_full_ff;
  logic [3:0] div_half_ff;

  genvar gd;
  generate
    for (gd = 0; gd < 4; gd++) begin : g_div
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          div_full_ff[gd] <= 1'b0;
          div_half_ff[gd] <= 1'b0;
        end else begin
          div_full_ff[gd] <= divider_pulse[gd];
          div_half_ff[gd] <= div_half_ff[gd] ^ divider_pulse[gd];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // status pin drive
  // ****************************************************************
  spr_src_s src;
  spr_drive_s drv [4];
  logic [3:0] pin_out_ff;
  logic [3:0] pin_oe_n_ff;
  logic [1:0] pull_up_ff;
  logic [1:0] pull_dn_ff;

  assign src.ref_lock = ref_loop_lock_detect;
  assign src.synth_lock = synth_loop_lock_detect;
  assign src.holdover = holdover_ff;
  assign src.dac_locked = dac_locked;
  assign src.readback = readback_ff[WORD_W-1];
  assign src.dac_rail = dac_rail;
  assign src.dac_low = dac_low;
  assign src.dac_high = dac_high;
  assign src.div_full = div_full_ff;
  assign src.div_half = div_half_ff;

  // lock and holdover pins cannot be inputs, so input types drive low
  assign drv[0] = pin_drive(lk_type, wide_src(lk_src, src), 1'b0);
  assign drv[1] = pin_drive(ho_type, wide_src(ho_src, src), 1'b0);

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_in_pin
      assign drv[gp+2] = pin_drive(in_type[gp],
                                   narrow_src(in_src[gp], ref_input_los[gp],
                                              ref_sel_ff == 2'(gp), src),
                                   1'b1);
      // pulls only apply while the pin is typed as an input
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pull_up_ff[gp] <= 1'b0;
          pull_dn_ff[gp] <= 1'b0;
        end else begin
          pull_up_ff[gp] <= (in_type[gp] == TY_IN_PU);
          pull_dn_ff[gp] <= (in_type[gp] == TY_IN_PD);
        end
      end
    end
    for (gp = 0; gp < 4; gp++) begin : g_pin
      // registered so pins never glitch on decode changes
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_out_ff[gp] <= 1'b0;
          pin_oe_n_ff[gp] <= 1'b1;
        end else begin
          pin_out_ff[gp] <= drv[gp].out;
          pin_oe_n_ff[gp] <= drv[gp].oe_n;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // sync hold and loop-side outputs
  // ****************************************************************
  logic sync_force_ff;
  logic track_ff;

  // relies on software keeping qualification off while holding
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_force_ff <= 1'b0;
      track_ff <= 1'b0;
    end else begin
      sync_force_ff <= (lock_word_ff[SYNC_SYNTH_BIT] & ~synth_loop_lock_detect)
                     | (lock_word_ff[SYNC_REF_BIT] & ~ref_loop_lock_detect);
      track_ff <= lock_word_ff[TRACK_BIT];
    end
  end

  assign status_pin_out = pin_out_ff;
  assign status_pin_oe_n = pin_oe_n_ff;
  assign status_pull_up = pull_up_ff;
  assign status_pull_dn = pull_dn_ff;
  assign ref_select = ref_sel_ff;
  assign holdover_active = holdover_ff;
  assign clock_switch_event = switch_ff;
  assign sync_force = sync_force_ff;
  assign dac_track_en = track_ff;
endmodule
`default_nettype wire
